// ===== src/acb_pkg.sv
/*
 Shared constants, field layouts and coding helpers for the converter control block.
 Assumes a 50 MHz system clock and a host on a byte-wide parallel bus.
*/
package acb_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int POR_TIME_NS = 10000;
   localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_TIME_NS = 3600;
   localparam int CONV_TICKS = 13;
   localparam int ACQ_TICKS = 3;
   // Internal tick period rounds down so the conversion never exceeds its budget
   localparam int INT_TICK_CYC = CONV_TIME_NS / (CONV_TICKS * CLK_PERIOD_NS);
   localparam int POR_W = 9;
   localparam int TICK_W = 4;
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYC - 1);
   localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(INT_TICK_CYC - 1);
   localparam logic [TICK_W-1:0] ACQ_LAST = TICK_W'(ACQ_TICKS - 1);
   localparam logic [TICK_W-1:0] CONV_LAST = TICK_W'(CONV_TICKS - 1);

   // ==========================================================
   // Control byte layout
   localparam int PM_HI_POS = 7;
   localparam int PM_LO_POS = 6;
   localparam int SAMPLE_PHASE_POS = 5;
   localparam int INPUT_CFG_POS = 4;
   localparam int POLARITY_POS = 3;
   localparam int ADDR_MSB = 2;
   localparam int ADDR_LSB = 0;
   localparam int RES_W = 10;
   localparam int MSB_POS = RES_W - 1;

   // Power mode field codes
   localparam logic [1:0] PM_SHUTDOWN = 2'h0;
   localparam logic [1:0] PM_STANDBY = 2'h1;
   localparam logic [1:0] PM_NORM_INT = 2'h2;
   localparam logic [1:0] PM_NORM_EXT = 2'h3;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic CLK_MODE_RST = 1'b1;
   localparam logic [RES_W-1:0] RESULT_RST = 10'h000;

   typedef struct packed {
      logic [1:0] power_mode;
      logic sample_phase_select;
      logic input_config_select;
      logic polarity_select;
      logic [2:0] channel_addr;
   } acb_ctrl_s;

   typedef struct packed {
      logic [7:0] pos_sel;
      logic [7:0] neg_sel;
      logic com_neg;
   } acb_mux_s;

   typedef enum {ST_IDLE, ST_ACQ, ST_CONV} acb_conv_e;
   typedef enum {PW_NORMAL, PW_STANDBY, PW_SHUTDOWN} acb_power_e;

   // Straight binary when unipolar, two's complement when bipolar
   function automatic logic [RES_W-1:0] acb_code(input logic [RES_W-1:0] raw,
                                                input logic unipolar);
      acb_code = unipolar ? raw : {~raw[MSB_POS], raw[MSB_POS-1:0]};
   endfunction : acb_code

   function automatic logic [7:0] acb_read_byte(input logic [RES_W-1:0] res,
                                                input logic upper,
                                                input logic unipolar);
      logic fill;
      fill = unipolar ? 1'b0 : res[MSB_POS];
      acb_read_byte = upper ? {{6{fill}}, res[MSB_POS:8]} : res[7:0];
   endfunction : acb_read_byte

endpackage : acb_pkg

// ===== src/acb_chan_dec.sv
/*
 Analog multiplexer select decoder for the converter control block.
 Purely combinational; the caller registers its outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module acb_chan_dec #(
   parameter bit EIGHT_CHANNELS = 1'b1
) (
   input wire acb_pkg::acb_ctrl_s ctrl,
   output acb_pkg::acb_mux_s mux
);
   import acb_pkg::*;

   logic [2:0] addr;

   // ==========================================================
   // Decode
   always_comb begin
      // Upper inputs are absent on the four-input part
      addr = ctrl.channel_addr;
      if (!EIGHT_CHANNELS) begin
         addr[ADDR_MSB] = 1'b0;
      end
      mux.pos_sel = 8'h00;
      mux.neg_sel = 8'h00;
      mux.com_neg = 1'b0;
      if (ctrl.input_config_select) begin
         mux.pos_sel[addr] = 1'b1;
         mux.com_neg = 1'b1;
      end else begin
         mux.pos_sel[{addr[2:1], addr[0]}] = 1'b1;
         mux.neg_sel[{addr[2:1], ~addr[0]}] = 1'b1;
      end
   end

endmodule : acb_chan_dec

`default_nettype wire

// ===== src/acb_top.sv
/*
 Control byte, conversion sequencing, power modes and result readback
 of a 10-bit successive-approximation converter with a byte-wide bus.
 Assumes bus pins synchronous to sys_clk and an analog core that
 delivers its raw straight-binary code on conv_code_in.
*/
// Function
// - Control byte fields in bits seven to zero
// - Single-ended: address picks input, common negative
// - Differential: pair by upper bits, bit0 polarity
// - Inputs four to seven only on eight-channel
// - Reset into external clock, done high
// - Upper byte select picks result byte
// - Power-down keeps bus alive, stops conversions
// - Standby wakes on write strobe rising edge
// - Shutdown after current conversion completes
// - Write strobe rising edge leaves shutdown
// - Unipolar result straight binary, 1024 steps
// - Power bits decode modes and clock
// - Power-down keeps last normal clock mode
// - Bipolar result in two's complement
`timescale 1ns/1ps
`default_nettype none

module acb_top #(
   parameter bit EIGHT_CHANNELS = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic upper_byte_select,
   input wire logic conv_clk,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   input wire logic [acb_pkg::RES_W-1:0] conv_code_in,
   output logic conv_done_n,
   output logic track_hold,
   output logic sar_run,
   output logic core_power_on,
   output logic ref_power_on,
   output logic por_busy,
   output logic ext_clock_mode,
   output acb_pkg::acb_mux_s mux_sel
);
   import acb_pkg::*;

   // ==========================================================
   // Pin history and strobe edges
   logic wr_n_q;
   logic rd_n_q;
   logic conv_clk_q;
   logic wr_rise;
   logic rd_fall;
   logic ext_tick;
   logic int_tick;
   logic tick;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         conv_clk_q <= 1'b0;
      end else begin
         wr_n_q <= wr_n;
         rd_n_q <= rd_n;
         conv_clk_q <= conv_clk;
      end
   end

   // Chip select must be low at the strobe edge for it to count
   assign wr_rise = wr_n && !wr_n_q && !cs_n;
   assign rd_fall = !rd_n && rd_n_q && !cs_n;
   // The external clock is gated off while the chip is deselected
   assign ext_tick = conv_clk && !conv_clk_q && !cs_n;

   // ==========================================================
   // Control state
   logic [7:0] cap_q;
   logic [7:0] cap_d;
   acb_ctrl_s ctrl_q;
   acb_ctrl_s ctrl_d;
   logic clk_mode_q;
   logic clk_mode_d;
   acb_conv_e state_q;
   acb_conv_e state_d;
   acb_power_e power_q;
   acb_power_e power_d;
   logic [1:0] pend_pm_q;
   logic [1:0] pend_pm_d;
   logic [TICK_W-1:0] div_q;
   logic [TICK_W-1:0] div_d;
   logic [TICK_W-1:0] cnt_q;
   logic [TICK_W-1:0] cnt_d;
   logic [POR_W-1:0] por_q;
   logic [POR_W-1:0] por_d;
   logic por_done;
   logic [RES_W-1:0] result_q;
   logic [RES_W-1:0] result_d;
   logic res_uni_q;
   logic res_uni_d;
   logic done_n_q;
   logic done_n_d;
   acb_ctrl_s wr_byte;

   assign por_done = (por_q == POR_LAST);
   assign int_tick = (div_q == DIV_LAST);
   assign tick = clk_mode_q ? ext_tick : int_tick;
   assign wr_byte = acb_ctrl_s'(cap_q);

   always_comb begin
      cap_d = cap_q;
      ctrl_d = ctrl_q;
      clk_mode_d = clk_mode_q;
      state_d = state_q;
      power_d = power_q;
      pend_pm_d = pend_pm_q;
      div_d = div_q;
      cnt_d = cnt_q;
      por_d = por_q;
      result_d = result_q;
      res_uni_d = res_uni_q;
      done_n_d = done_n_q;

      // Writes before the internal reset period ends are dropped
      if (!por_done) begin
         por_d = por_q + POR_W'(1);
      end

      // Byte follows the pins while the strobe is low, last value wins
      if (!cs_n && !wr_n) begin
         cap_d = data_in;
      end

      // Internal conversion clock divider runs only while busy
      if (state_q == ST_IDLE || int_tick) begin
         div_d = '0;
      end else begin
         div_d = div_q + TICK_W'(1);
      end

      // A read of the result clears the done flag
      if (rd_fall) begin
         done_n_d = 1'b1;
      end

      unique case (state_q)
         ST_IDLE: begin
         end
         ST_ACQ: begin
            if (!ctrl_q.sample_phase_select && tick) begin
               cnt_d = cnt_q + TICK_W'(1);
               if (cnt_q == ACQ_LAST) begin
                  state_d = ST_CONV;
                  cnt_d = '0;
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               cnt_d = cnt_q + TICK_W'(1);
               if (cnt_q == CONV_LAST) begin
                  state_d = ST_IDLE;
                  cnt_d = '0;
                  result_d = acb_code(conv_code_in, ctrl_q.polarity_select);
                  res_uni_d = ctrl_q.polarity_select;
                  // Power-down waits for the conversion to finish
                  if (pend_pm_q == PM_SHUTDOWN) begin
                     power_d = PW_SHUTDOWN;
                  end else if (pend_pm_q == PM_STANDBY) begin
                     power_d = PW_STANDBY;
                  end
               end
            end
         end
      endcase

      // A write mid-conversion is refused so the running result stays intact
      if (wr_rise && por_done && state_q != ST_CONV) begin
         ctrl_d = wr_byte;
         pend_pm_d = wr_byte.power_mode;
         power_d = PW_NORMAL;
         done_n_d = 1'b1;
         cnt_d = '0;
         if (wr_byte.power_mode[PM_HI_POS-PM_LO_POS]) begin
            clk_mode_d = wr_byte.power_mode[0];
         end else begin
            clk_mode_d = clk_mode_q;
         end
         // In external acquisition the second write ends tracking
         if (state_q == ST_ACQ && ctrl_q.sample_phase_select) begin
            state_d = ST_CONV;
         end else begin
            state_d = ST_ACQ;
         end
      end

      // Conversion end beats a same-cycle read clear
      if (state_q == ST_CONV && tick && cnt_q == CONV_LAST) begin
         done_n_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cap_q <= CTRL_RST;
         ctrl_q <= acb_ctrl_s'(CTRL_RST);
         clk_mode_q <= CLK_MODE_RST;
         state_q <= ST_IDLE;
         power_q <= PW_NORMAL;
         pend_pm_q <= PM_NORM_EXT;
         div_q <= '0;
         cnt_q <= '0;
         por_q <= '0;
         result_q <= RESULT_RST;
         res_uni_q <= 1'b0;
         done_n_q <= 1'b1;
      end else begin
         cap_q <= cap_d;
         ctrl_q <= ctrl_d;
         clk_mode_q <= clk_mode_d;
         state_q <= state_d;
         power_q <= power_d;
         pend_pm_q <= pend_pm_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         por_q <= por_d;
         result_q <= result_d;
         res_uni_q <= res_uni_d;
         done_n_q <= done_n_d;
      end
   end

   // ==========================================================
   // Analog-side controls, registered from next state
   acb_mux_s mux_d;
   logic track_q;
   logic sar_q;
   logic core_on_q;
   logic ref_on_q;
   logic por_busy_q;
   acb_mux_s mux_q;

   acb_chan_dec #(
      .EIGHT_CHANNELS(EIGHT_CHANNELS)
   ) u_chan_dec (
      .ctrl(ctrl_d),
      .mux(mux_d)
   );

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         track_q <= 1'b0;
         sar_q <= 1'b0;
         core_on_q <= 1'b1;
         ref_on_q <= 1'b1;
         por_busy_q <= 1'b1;
         mux_q <= '0;
      end else begin
         track_q <= (state_d == ST_ACQ);
         sar_q <= (state_d == ST_CONV);
         core_on_q <= (power_d == PW_NORMAL);
         ref_on_q <= (power_d != PW_SHUTDOWN);
         por_busy_q <= (por_d != POR_LAST);
         mux_q <= mux_d;
      end
   end

   // ==========================================================
   // Parallel read path, active in every power mode
   logic [7:0] dout_q;
   logic [7:0] dout_d;
   logic oe_n_q;
   logic oe_n_d;

   always_comb begin
      oe_n_d = !(!cs_n && !rd_n);
      dout_d = acb_read_byte(result_q, upper_byte_select, res_uni_q);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dout_q <= 8'h00;
         oe_n_q <= 1'b1;
      end else begin
         dout_q <= dout_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ==========================================================
   // Outputs
   assign data_out = dout_q;
   assign data_oe_n = oe_n_q;
   assign conv_done_n = done_n_q;
   assign track_hold = track_q;
   assign sar_run = sar_q;
   assign core_power_on = core_on_q;
   assign ref_power_on = ref_on_q;
   assign por_busy = por_busy_q;
   assign ext_clock_mode = clk_mode_q;
   assign mux_sel = mux_q;

endmodule : acb_top

`default_nettype wire

// ===== verif/acb_asserts.sv
/*
 Port checker for acb_top: write capture, mux decode, power and read rules.
 Assumes the eight-channel build and is attached to acb_top by bind.
*/
`timescale 1ns/1ps
`default_nettype none

module acb_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic upper_byte_select,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic conv_done_n,
   input wire logic track_hold,
   input wire logic sar_run,
   input wire logic core_power_on,
   input wire logic ref_power_on,
   input wire logic por_busy,
   input wire logic ext_clock_mode,
   input wire acb_pkg::acb_mux_s mux_sel
);
   import acb_pkg::*;

   // ====================
   // Helpers
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   function automatic acb_mux_s mux_exp(input logic [7:0] b);
      mux_exp = '0;
      if (b[4]) begin
         mux_exp.pos_sel[b[2:0]] = 1'b1;
         mux_exp.com_neg = 1'b1;
      end else begin
         mux_exp.pos_sel[{b[2:1], b[0]}] = 1'b1;
         mux_exp.neg_sel[{b[2:1], ~b[0]}] = 1'b1;
      end
   endfunction : mux_exp

   // Strobe low then high with the part free to take it
   sequence wr_take;
      !cs_n && !wr_n ##1 !cs_n && wr_n && !por_busy && !sar_run;
   endsequence

   // ====================
   // Properties
   a_oe_on_read: assert property (!cs_n && !rd_n |=> !data_oe_n)
      else $error("bus not driven during read");
   a_oe_off_idle: assert property (cs_n || rd_n |=> data_oe_n)
      else $error("bus driven outside read");
   a_upper_fill: assert property (!cs_n && !rd_n && upper_byte_select |=>
      data_out[7:2] == 6'h00 || data_out[7:2] == {6{data_out[1]}})
      else $error("upper byte fill wrong");
   a_por_state: assert property (por_busy |-> conv_done_n && ext_clock_mode)
      else $error("reset state wrong");
   a_mux_single: assert property (wr_take ##0 $past(data_in[4]) |=>
      mux_sel == mux_exp($past(data_in, 2)))
      else $error("single-ended select wrong");
   a_mux_pair: assert property (wr_take ##0 !$past(data_in[4]) |=>
      mux_sel == mux_exp($past(data_in, 2)))
      else $error("pair select wrong");
   a_clk_select: assert property (wr_take ##0 $past(data_in[7]) |=>
      ext_clock_mode == $past(data_in[6], 2))
      else $error("clock mode not taken");
   a_clk_keep: assert property (wr_take ##0 !$past(data_in[7]) |=>
      $stable(ext_clock_mode))
      else $error("clock mode lost in power-down");
   // Second byte of an external acquisition goes straight to converting
   a_write_wakes: assert property (wr_take |=>
      core_power_on && (track_hold ^ sar_run))
      else $error("write did not wake");
   a_shutdown_exit: assert property (wr_take |=> ref_power_on)
      else $error("shutdown not left");
   a_busy_powered: assert property (sar_run |-> ref_power_on)
      else $error("shutdown during conversion");
   a_pd_no_conv: assert property (!core_power_on |-> !sar_run && !track_hold)
      else $error("conversion while powered down");

endmodule : acb_asserts

bind acb_top acb_asserts acb_asserts_i (.sys_clk, .rst, .cs_n, .wr_n, .rd_n,
   .upper_byte_select, .data_in, .data_out, .data_oe_n, .conv_done_n, .track_hold,
   .sar_run, .core_power_on, .ref_power_on, .por_busy, .ext_clock_mode, .mux_sel);

`default_nettype wire

// ===== verif/acb_host.sv
/*
 Host model on the byte-wide bus: write, read and external clock tasks.
 Assumes the bench calls one task at a time, all timed on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module acb_host (
   input wire logic sys_clk,
   output logic cs_n,
   output logic wr_n,
   output logic rd_n,
   output logic upper_byte_select,
   output logic conv_clk,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out
);
   // ====================
   // Bus tasks
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      upper_byte_select = 1'b0;
      conv_clk = 1'b0;
      data_in = 8'h00;
   end

   task automatic wr(input logic [7:0] b);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      data_in <= b;
      @(posedge sys_clk);
      wr_n <= 1'b1;
      @(posedge sys_clk);
      cs_n <= 1'b1;
      // Released pins must not keep showing the byte
      data_in <= ~b;
   endtask : wr

   task automatic rd(input logic u, output logic [7:0] v);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      upper_byte_select <= u;
      repeat (2) @(posedge sys_clk);
      #1 v = data_out;
      @(posedge sys_clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask : rd

   // Clock only inside a selected frame; it stands low otherwise
   task automatic ticks(input int n);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (n) begin
         repeat (2) @(posedge sys_clk);
         conv_clk <= 1'b1;
         repeat (2) @(posedge sys_clk);
         conv_clk <= 1'b0;
      end
      @(posedge sys_clk);
      cs_n <= 1'b1;
   endtask : ticks

endmodule : acb_host

`default_nettype wire

// ===== verif/tb.sv
/*
 Self-checking bench for acb_top: random conversions, modes, power-down.
 Assumes acb_host as bus partner and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   import acb_pkg::*;

   logic sys_clk, rst, cs_n, wr_n, rd_n, ube, conv_clk;
   logic [7:0] din, dout, b, v;
   logic [9:0] code;
   logic oe_n, done_n, th, run, core_on, ref_on, por, ext;
   acb_mux_s mux;
   logic [31:0] seed;
   int fails, checks_done, n;
   logic u;

   // Host waits in system clock cycles; the reference settle wait dominates the run
   localparam int REF_SETTLE_CYC = 500000 / CLK_PERIOD_NS;
   localparam int EXT_REF_WAKE_CYC = 50000 / CLK_PERIOD_NS;
   localparam int WATCHDOG_CYC = 40000;

   acb_host acb_host_i (.sys_clk(sys_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
      .upper_byte_select(ube), .conv_clk(conv_clk), .data_in(din), .data_out(dout));
   acb_top acb_top_i (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
      .rd_n(rd_n), .upper_byte_select(ube), .conv_clk(conv_clk), .data_in(din),
      .data_out(dout), .data_oe_n(oe_n), .conv_code_in(code), .conv_done_n(done_n),
      .track_hold(th), .sar_run(run), .core_power_on(core_on), .ref_power_on(ref_on),
      .por_busy(por), .ext_clock_mode(ext), .mux_sel(mux));

   // ====================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction : lfsr

   // Bipolar output is the offset code with its top bit flipped
   function automatic logic [7:0] exp_byte(input logic [9:0] r, input logic up, uni);
      logic [9:0] c;
      c = uni ? r : {~r[9], r[8:0]};
      exp_byte = up ? {{6{uni ? 1'b0 : c[9]}}, c[9:8]} : c[7:0];
   endfunction : exp_byte

   task automatic check(input string what, input logic [9:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_done;
      n = 0;
      while (done_n !== 1'b0 && n < 600) begin
         @(posedge sys_clk);
         n++;
      end
      #1 check("done", done_n, 1'b0);
   endtask : wait_done

   task automatic complete_run;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // ====================
   // Clock, watchdog
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (WATCHDOG_CYC) @(posedge sys_clk);
      fails++;
      complete_run();
   end

   // ====================
   // Sequence
   initial begin
      rst = 1'b1;
      code = 10'h000;
      fails = 0;
      checks_done = 0;
      seed = 32'hB548;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      #1 check("por", {done_n, ext, por}, 3'h7);
      n = 0;
      while (por !== 1'b0 && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
      check("por end", por, 1'b0);
      // Results are only trusted once the on-chip reference has settled
      repeat (REF_SETTLE_CYC) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         b = {2'b10, 1'b0, seed[4:0]};
         u = seed[20];
         code <= (i < 2) ? {10{i[0]}} : seed[17:8];
         acb_host_i.wr(b);
         wait_done();
         check("clock mode", ext, 1'b0);
         acb_host_i.rd(u, v);
         check("first byte", v, exp_byte(code, u, b[3]));
         acb_host_i.rd(!u, v);
         check("second byte", v, exp_byte(code, !u, b[3]));
      end
      acb_host_i.wr(8'hD1);
      acb_host_i.ticks(18);
      check("ext done", {done_n, ext}, 2'h1);
      // External acquisition: tracking lasts until the next accepted byte
      seed = lfsr(seed);
      code <= seed[9:0];
      acb_host_i.wr(8'hF2);
      acb_host_i.ticks(4);
      check("ext acquire", {th, run}, 2'h2);
      acb_host_i.wr(8'hF2);
      acb_host_i.ticks(14);
      check("ext acq done", done_n, 1'b0);
      acb_host_i.rd(1'b1, v);
      check("bipolar high", v, exp_byte(code, 1'b1, 1'b0));
      acb_host_i.rd(1'b0, v);
      check("bipolar low", v, exp_byte(code, 1'b0, 1'b0));
      acb_host_i.wr(8'h51);
      acb_host_i.ticks(18);
      #1 check("standby", {core_on, ref_on, ext}, 3'h3);
      acb_host_i.rd(1'b0, v);
      check("standby read", v, exp_byte(code, 1'b0, 1'b0));
      acb_host_i.wr(8'h99);
      @(posedge sys_clk);
      #1 check("standby wake", core_on, 1'b1);
      wait_done();
      acb_host_i.wr(8'h01);
      @(posedge sys_clk);
      #1 check("shutdown busy", {ref_on, th}, 2'h3);
      wait_done();
      repeat (2) @(posedge sys_clk);
      #1 check("shutdown", {core_on, ref_on, ext}, 3'h0);
      acb_host_i.wr(8'h9E);
      @(posedge sys_clk);
      #1 check("shutdown wake", {core_on, ref_on}, 2'h3);
      check("upper input", mux.pos_sel, 8'h40);
      wait_done();
      // Settle wait assumes an external reference on the board
      repeat (EXT_REF_WAKE_CYC) @(posedge sys_clk);
      seed = lfsr(seed);
      code <= seed[9:0];
      acb_host_i.wr(8'h9E);
      // Wait past acquisition so the next byte lands mid-conversion
      repeat (60) @(posedge sys_clk);
      acb_host_i.wr(8'hD1);
      #1 check("refused write", ext, 1'b0);
      wait_done();
      acb_host_i.rd(1'b0, v);
      check("wake result", v, exp_byte(code, 1'b0, 1'b1));
      complete_run();
   end

endmodule : tb

`default_nettype wire
